// >>> uerc_pkg.sv
/*
 Package for the USB event interrupt and receive endpoint settings block.
 Holds register offsets, field positions, reset values, codes and carrier structs.
 Assumes a 32-bit AHB-Lite register bus and a 100 MHz clock.
*/
package uerc_pkg;
    localparam logic [7:0] UERC_OFS_EVT = 8'h00;
    localparam logic [7:0] UERC_OFS_CFG = 8'h04;
    localparam logic [7:0] UERC_OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] UERC_OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] UERC_OFS_EP_SEL = 8'h10;
    localparam logic [7:0] UERC_OFS_EP_STAT = 8'h14;

    localparam int UERC_EN_LSB = 24;
    localparam int UERC_FLAG_LSB = 16;
    localparam int UERC_EP_LSB = 1;
    localparam int UERC_NUM_EP = 7;
    localparam logic [7:0] UERC_EN_RESET = 8'h06;
    localparam logic [6:0] UERC_EP_EN_RESET = 7'h7F;

    localparam int UERC_IVL_LSB = 8;
    localparam int UERC_SPD_LSB = 6;
    localparam int UERC_PRO_LSB = 4;
    localparam int UERC_TEP_LSB = 0;

    localparam logic [1:0] UERC_SPD_LOW = 2'h3;
    localparam logic [1:0] UERC_SPD_FULL = 2'h2;
    localparam logic [1:0] UERC_SPD_HIGH = 2'h1;
    localparam logic [1:0] UERC_PRO_INTR = 2'h3;
    localparam logic [1:0] UERC_PRO_BULK = 2'h2;
    localparam logic [1:0] UERC_PRO_ISO = 2'h1;
    localparam logic [1:0] UERC_PRO_CTRL = 2'h0;

    localparam logic [7:0] UERC_IVL_MIN = 8'h01;
    localparam logic [7:0] UERC_IVL_EXP_MAX = 8'h10;
    localparam logic [7:0] UERC_NAK_MIN = 8'h02;

    localparam logic [1:0] UERC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] UERC_HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic bus_supply_error;
        logic session_request;
        logic disconnect;
        logic connect;
        logic frame_start;
        logic bus_reset_babble;
        logic resume;
        logic suspend;
    } uerc_evt_t;

    typedef struct packed {
        logic [7:0] rx_poll_interval_nak_limit;
        logic [1:0] speed;
        logic [1:0] protocol;
        logic [3:0] rx_target_endpoint_number;
    } uerc_epcfg_t;
endpackage

// >>> uerc_evt_detect.sv
/*
 Event detector: turns the link status levels into one-cycle event pulses.
 Assumes all link inputs are synchronous to REF_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module uerc_evt_detect
    import uerc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic host_mode,
    input wire logic vbus_valid,
    input wire logic session_active,
    input wire logic session_req_seen,
    input wire logic peer_attached,
    input wire logic frame_start_seen,
    input wire logic bus_reset_seen,
    input wire logic babble_seen,
    input wire logic resume_seen,
    input wire logic suspend_seen,
    output uerc_pkg::uerc_evt_t evt
);
    logic vbus_valid_d;
    logic session_d;
    logic attached_d;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vbus_valid_d <= 1'b0;
            session_d <= 1'b0;
            attached_d <= 1'b0;
        end else begin
            vbus_valid_d <= vbus_valid;
            session_d <= session_active;
            attached_d <= peer_attached;
        end
    end

    always_comb begin
        evt.bus_supply_error = vbus_valid_d && !vbus_valid && session_active;
        evt.session_request = session_req_seen;
        evt.disconnect = host_mode ? (attached_d && !peer_attached)
                                   : (session_d && !session_active);
        evt.connect = host_mode && !attached_d && peer_attached;
        evt.frame_start = frame_start_seen;
        evt.bus_reset_babble = host_mode ? babble_seen : bus_reset_seen;
        evt.resume = resume_seen;
        evt.suspend = suspend_seen;
    end
endmodule
`default_nettype wire

// >>> uerc_poll_timer.sv
/*
 Per-endpoint poll and NAK time-out timer counting frames or microframes.
 Assumes frame_tick pulses once per frame or microframe.
*/
`timescale 1ns/1ps
`default_nettype none
module uerc_poll_timer
    import uerc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire uerc_pkg::uerc_epcfg_t cfg,
    input wire logic frame_tick,
    input wire logic nak_seen,
    input wire logic data_seen,
    output logic poll_due,
    output logic nak_timeout
);
    logic [15:0] count;
    logic [15:0] limit;
    logic active;
    logic is_bulk;

    function automatic logic [15:0] pow2m1(input logic [7:0] m);
        pow2m1 = 16'h0001 << (m[4:0] - 5'h01);
    endfunction

    always_comb begin
        is_bulk = (cfg.protocol == UERC_PRO_BULK);
        limit = 16'h0000;
        active = 1'b0;
        case (cfg.protocol)
            UERC_PRO_INTR: begin
                active = (cfg.rx_poll_interval_nak_limit >= UERC_IVL_MIN);
                if (cfg.speed == UERC_SPD_HIGH) begin
                    limit = pow2m1(cfg.rx_poll_interval_nak_limit);
                    active = active && (cfg.rx_poll_interval_nak_limit <= UERC_IVL_EXP_MAX);
                end else begin
                    limit = {8'h00, cfg.rx_poll_interval_nak_limit};
                end
            end
            UERC_PRO_ISO: begin
                limit = pow2m1(cfg.rx_poll_interval_nak_limit);
                active = (cfg.rx_poll_interval_nak_limit >= UERC_IVL_MIN)
                      && (cfg.rx_poll_interval_nak_limit <= UERC_IVL_EXP_MAX);
            end
            UERC_PRO_BULK: begin
                limit = pow2m1(cfg.rx_poll_interval_nak_limit);
                active = (cfg.rx_poll_interval_nak_limit >= UERC_NAK_MIN)
                      && (cfg.rx_poll_interval_nak_limit <= UERC_IVL_EXP_MAX);
            end
            default: begin
                limit = 16'h0000;
                active = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 16'h0000;
            poll_due <= 1'b0;
            nak_timeout <= 1'b0;
        end else begin
            poll_due <= 1'b0;
            nak_timeout <= 1'b0;
            if (!active || (is_bulk && data_seen)) begin
                count <= 16'h0000;
            end else if (frame_tick && (!is_bulk || nak_seen)) begin
                if (count + 16'h0001 >= limit) begin
                    count <= 16'h0000;
                    poll_due <= !is_bulk;
                    nak_timeout <= is_bulk;
                end else begin
                    count <= count + 16'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> uerc_top.sv
/*
 USB event interrupt register and receive endpoint settings, AHB-Lite slave.
 Assumes a single AHB-Lite master, word transfers, link status synchronous to REF_CLK.
*/
//
// Behaviour
// - Eight writable event enables in bits 31:24; reset/babble and resume reset set.
// - Eight read-only hardware-set event flags in bits 23:16, reset to zero.
// - Bus supply error flag sets when supply drops invalid during a session.
// - Session request flag sets when session request signalling is seen.
// - Disconnect flag: host sees peer leave; peripheral sees session end.
// - Connect flag sets when, as host, a peripheral attaches.
// - Reset/babble source: bus reset as peripheral, babble as host, one enable.
// - Frame start, resume, suspend interrupts gated by their own enables.
// - Interrupt endpoint at low/full speed polls every m frames, m 1..255.
// - Interrupt endpoint at high speed polls every 2^(m-1) frames, m 1..16.
// - Isochronous endpoint polls every 2^(m-1) frames, m 1..16.
// - Bulk endpoint times out after 2^(m-1) NAK frames; m 0 or 1 disables.
// - Speed field bits 7:6: 11 low, 10 full, 01 high, 00 reserved.
// - Protocol field bits 5:4: 11 interrupt, 10 bulk, 01 iso, 00 control.
`timescale 1ns/1ps
`default_nettype none
module uerc_top
    import uerc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic IRQ,
    output logic [6:0] EP_RX_IRQ,
    output logic [6:0] EP_POLL_DUE,
    output logic [6:0] EP_NAK_TIMEOUT,
    input wire logic HOST_MODE,
    input wire logic VBUS_VALID,
    input wire logic SESSION_ACTIVE,
    input wire logic SESSION_REQ_SEEN,
    input wire logic PEER_ATTACHED,
    input wire logic FRAME_START_SEEN,
    input wire logic BUS_RESET_SEEN,
    input wire logic BABBLE_SEEN,
    input wire logic RESUME_SEEN,
    input wire logic SUSPEND_SEEN,
    input wire logic FRAME_TICK,
    input wire logic [6:0] EP_RX_DONE,
    input wire logic [6:0] EP_NAK_SEEN,
    input wire logic [6:0] EP_DATA_SEEN
);
    logic [7:0] evt_en;
    uerc_evt_t evt_flag;
    uerc_evt_t evt;
    logic [6:0] ep_rx_en;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [6:0] ep_rx_stat;
    logic [2:0] ep_sel;
    uerc_epcfg_t ep_cfg [UERC_NUM_EP];
    logic [6:0] poll_due;
    logic [6:0] nak_to;

    logic wr_pend;
    logic [7:0] wr_ofs;
    logic rd_now;
    logic [7:0] rd_ofs;
    logic evt_rd;
    logic stat_rd;
    logic epstat_rd;
    logic addr_ok;
    logic [31:0] next_rdata;

    // One decode for the write and the read path, so the two can never disagree on the slot.
    function automatic logic [2:0] ep_index(input logic [2:0] sel);
        ep_index = (sel == 3'h0) ? 3'h0 : sel - 3'h1;
    endfunction

    uerc_evt_detect u_det (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .host_mode(HOST_MODE),
        .vbus_valid(VBUS_VALID),
        .session_active(SESSION_ACTIVE),
        .session_req_seen(SESSION_REQ_SEEN),
        .peer_attached(PEER_ATTACHED),
        .frame_start_seen(FRAME_START_SEEN),
        .bus_reset_seen(BUS_RESET_SEEN),
        .babble_seen(BABBLE_SEEN),
        .resume_seen(RESUME_SEEN),
        .suspend_seen(SUSPEND_SEEN),
        .evt(evt)
    );

    genvar g;
    generate
        for (g = 0; g < UERC_NUM_EP; g++) begin : g_ep
            uerc_poll_timer u_tmr (
                .clk(REF_CLK),
                .rst_n(RST_N),
                .cfg(ep_cfg[g]),
                .frame_tick(FRAME_TICK),
                .nak_seen(EP_NAK_SEEN[g]),
                .data_seen(EP_DATA_SEEN[g]),
                .poll_due(poll_due[g]),
                .nak_timeout(nak_to[g])
            );
        end
    endgenerate

    // Reads are answered with zero wait states, so the read data is latched at address time.
    assign addr_ok = HSEL && HREADY && (HTRANS == UERC_HTRANS_NONSEQ);
    assign rd_now = addr_ok && !HWRITE;
    assign rd_ofs = HADDR[7:0];
    assign evt_rd = rd_now && (rd_ofs == UERC_OFS_EVT);
    assign stat_rd = rd_now && (rd_ofs == UERC_OFS_IRQ_STAT);
    assign epstat_rd = rd_now && (rd_ofs == UERC_OFS_EP_STAT);

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend <= 1'b0;
            wr_ofs <= 8'h00;
        end else begin
            wr_pend <= addr_ok && HWRITE;
            wr_ofs <= HADDR[7:0];
        end
    end

    // Flags are visible to software but cannot be cleared here; the status copy does that.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            evt_flag <= '0;
        end else begin
            evt_flag <= evt_flag | evt;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            evt_en <= UERC_EN_RESET;
            ep_rx_en <= UERC_EP_EN_RESET;
            irq_mask <= 8'hFF;
            ep_sel <= 3'h0;
        end else if (wr_pend) begin
            case (wr_ofs)
                UERC_OFS_EVT: begin
                    evt_en <= HWDATA[UERC_EN_LSB +: 8];
                    ep_rx_en <= HWDATA[UERC_EP_LSB +: 7];
                end
                UERC_OFS_IRQ_MASK: irq_mask <= HWDATA[7:0];
                UERC_OFS_EP_SEL: ep_sel <= HWDATA[2:0];
                default: ep_sel <= ep_sel;
            endcase
        end
    end

    // The endpoint settings are indexed by the selector; value 0 falls back to endpoint 1.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < UERC_NUM_EP; i++) begin
                ep_cfg[i] <= '0;
            end
        end else if (wr_pend && (wr_ofs == UERC_OFS_CFG)) begin
            ep_cfg[ep_index(ep_sel)] <= HWDATA[15:0];
        end
    end

    // A gated event sets its sticky bit; the set wins over the read clear.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat <= 8'h00;
            ep_rx_stat <= 7'h00;
        end else begin
            irq_stat <= (stat_rd ? 8'h00 : irq_stat) | (evt & evt_en);
            ep_rx_stat <= (epstat_rd ? 7'h00 : ep_rx_stat) | (EP_RX_DONE & ep_rx_en);
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (rd_ofs)
            UERC_OFS_EVT: begin
                next_rdata[UERC_EN_LSB +: 8] = evt_en;
                next_rdata[UERC_FLAG_LSB +: 8] = evt_flag;
                next_rdata[UERC_EP_LSB +: 7] = ep_rx_en;
            end
            UERC_OFS_CFG: next_rdata[15:0] = ep_cfg[ep_index(ep_sel)];
            UERC_OFS_IRQ_STAT: next_rdata[7:0] = irq_stat;
            UERC_OFS_IRQ_MASK: next_rdata[7:0] = irq_mask;
            UERC_OFS_EP_SEL: next_rdata[2:0] = ep_sel;
            UERC_OFS_EP_STAT: next_rdata[6:0] = ep_rx_stat;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            IRQ <= 1'b0;
            EP_RX_IRQ <= 7'h00;
            EP_POLL_DUE <= 7'h00;
            EP_NAK_TIMEOUT <= 7'h00;
        end else begin
            if (rd_now) begin
                HRDATA <= next_rdata;
            end
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            IRQ <= |((irq_stat & irq_mask) | (evt & evt_en & irq_mask));
            EP_RX_IRQ <= ep_rx_stat;
            EP_POLL_DUE <= poll_due;
            EP_NAK_TIMEOUT <= nak_to;
        end
    end

    property p_en_reset;
        @(posedge REF_CLK) $rose(RST_N) |-> evt_en == UERC_EN_RESET;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("enable reset value wrong");

    property p_flag_sticky;
        @(posedge REF_CLK) disable iff (!RST_N) ##1 (evt_flag & $past(evt_flag)) == $past(evt_flag);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("event flag lost");

    property p_flag_set;
        @(posedge REF_CLK) disable iff (!RST_N)
            HOST_MODE && $rose(PEER_ATTACHED) && $past(RST_N) |=> evt_flag.connect;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("connect flag not set");

    property p_vbus;
        @(posedge REF_CLK) disable iff (!RST_N)
            $fell(VBUS_VALID) && SESSION_ACTIVE |=> evt_flag.bus_supply_error;
    endproperty
    a_vbus: assert property (p_vbus) else $error("supply error flag not set");

    property p_gate;
        @(posedge REF_CLK) disable iff (!RST_N)
            (evt.frame_start && !evt_en[3] && !stat_rd && !irq_stat[3]) |=> !irq_stat[3];
    endproperty
    a_gate: assert property (p_gate) else $error("disabled source raised status");

    sequence s_babble;
        HOST_MODE && BABBLE_SEEN && evt_en[2];
    endsequence
    property p_babble;
        @(posedge REF_CLK) disable iff (!RST_N) s_babble |=> irq_stat[2];
    endproperty
    a_babble: assert property (p_babble) else $error("babble not reported");

    property p_irq;
        @(posedge REF_CLK) disable iff (!RST_N) |(irq_stat & irq_mask) |=> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_bit0;
        @(posedge REF_CLK) disable iff (!RST_N) ##1 !(HRDATA[0] && $past(evt_rd));
    endproperty
    a_bit0: assert property (p_bit0) else $error("bit 0 not zero");

    property p_bulk_off;
        @(posedge REF_CLK) disable iff (!RST_N)
            ep_cfg[0].protocol == UERC_PRO_BULK && ep_cfg[0].rx_poll_interval_nak_limit < UERC_NAK_MIN
            |=> !nak_to[0];
    endproperty
    a_bulk_off: assert property (p_bulk_off) else $error("disabled time-out fired");

    property p_sess_req;
        @(posedge REF_CLK) disable iff (!RST_N) SESSION_REQ_SEEN |=> evt_flag.session_request;
    endproperty
    a_sess_req: assert property (p_sess_req) else $error("session request missed");

    // The first edge after reset is left out: the edge detectors still hold their reset value.
    property p_disc_host;
        @(posedge REF_CLK) disable iff (!RST_N)
            HOST_MODE && $fell(PEER_ATTACHED) && $past(RST_N) |=> evt_flag.disconnect;
    endproperty
    a_disc_host: assert property (p_disc_host) else $error("host disconnect missed");

    property p_disc_dev;
        @(posedge REF_CLK) disable iff (!RST_N)
            !HOST_MODE && $fell(SESSION_ACTIVE) && $past(RST_N) |=> evt_flag.disconnect;
    endproperty
    a_disc_dev: assert property (p_disc_dev) else $error("session end missed");

    sequence s_stat_clear;
        stat_rd && ((evt & evt_en) == 8'h00);
    endsequence
    property p_stat_clear;
        @(posedge REF_CLK) disable iff (!RST_N) s_stat_clear |=> irq_stat == 8'h00;
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");

    property p_ep_set;
        @(posedge REF_CLK) disable iff (!RST_N) |(EP_RX_DONE & ep_rx_en) |=> |ep_rx_stat;
    endproperty
    a_ep_set: assert property (p_ep_set) else $error("endpoint status missed");

    property p_ctrl_idle;
        @(posedge REF_CLK) disable iff (!RST_N)
            ep_cfg[5].protocol == UERC_PRO_CTRL |=> !poll_due[5] && !nak_to[5];
    endproperty
    a_ctrl_idle: assert property (p_ctrl_idle) else $error("control timer ran");
endmodule
`default_nettype wire

// >>> uerc_link_model.sv
/*
 Link-side partner: a USB host or peripheral seen as status levels and one-cycle pulses.
 Assumes it shares REF_CLK with the block and changes outputs just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module uerc_link_model (
    input wire logic clk,
    output logic host_mode,
    output logic vbus_valid,
    output logic session_active,
    output logic peer_attached,
    output logic [5:0] ev,
    output logic frame_tick,
    output logic [6:0] rx_done,
    output logic [6:0] nak_seen,
    output logic [6:0] data_seen
);
    initial begin
        {host_mode, vbus_valid, session_active, peer_attached} = 4'hE;
        {ev, frame_tick, rx_done, nak_seen, data_seen} = '0;
    end

    // The supply is restored one cycle after a drop, so only the falling edge is an event.
    task automatic act(input logic host, input logic [3:0] code);
        @(posedge clk);
        host_mode <= host;
        @(posedge clk);
        case (code)
            4'h0: peer_attached <= 1'b1;
            4'h1: peer_attached <= 1'b0;
            4'h2: vbus_valid <= 1'b0;
            4'h9: session_active <= 1'b0;
            4'hA: session_active <= 1'b1;
            default: ev <= 6'h01 << (code - 4'h3);
        endcase
        @(posedge clk);
        ev <= 6'h00;
        vbus_valid <= 1'b1;
    endtask

    task automatic frames(input int n, input logic [6:0] nak, input logic [6:0] dat);
        repeat (n) begin
            @(posedge clk);
            frame_tick <= 1'b1;
            nak_seen <= nak;
            data_seen <= dat;
            @(posedge clk);
            {frame_tick, nak_seen, data_seen} <= '0;
            repeat (2) @(posedge clk);
        end
    endtask

    task automatic rx(input logic [6:0] m);
        @(posedge clk);
        rx_done <= m;
        @(posedge clk);
        rx_done <= 7'h00;
    endtask
endmodule
`default_nettype wire

// >>> testbench.sv
/*
 Self-checking bench for the event interrupt and receive endpoint block.
 Assumes uerc_top as an AHB-Lite slave whose HREADYOUT is fed back as HREADY.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import uerc_pkg::*;
    logic REF_CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, IRQ, frame_tick;
    logic [31:0] HADDR, HWDATA, HRDATA, rd, w;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [5:0] ev;
    logic host_mode, vbus_valid, session_active, peer_attached;
    logic [6:0] EP_RX_IRQ, EP_POLL_DUE, EP_NAK_TIMEOUT, rx_done, nak_seen, data_seen;
    int n_mismatch = 0;
    int checks_done = 0;
    int seed = 82;
    int poll_cnt [7] = '{default: 0};
    int nak_cnt [7] = '{default: 0};
    logic [15:0] cfg [1:7];
    logic [15:0] t_cfg [1:7] = '{16'h03B1, 16'h0372, 16'h0293, 16'h0364, 16'h01A5,
        16'h0586, 16'hFFF7};
    // Entries hold host mode, link action and the status bit that must follow.
    logic [15:0] ev_tab [16] = '{16'h1010, 16'h1120, 16'h1280, 16'h1340, 16'h1408,
        16'h1604, 16'h1702, 16'h1801, 16'h0504, 16'h0920, 16'h0200, 16'h0A00,
        16'h0000, 16'h0100, 16'h1500, 16'h0600};

    uerc_top uerc_top_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .IRQ(IRQ), .EP_RX_IRQ(EP_RX_IRQ), .EP_POLL_DUE(EP_POLL_DUE),
        .EP_NAK_TIMEOUT(EP_NAK_TIMEOUT), .HOST_MODE(host_mode), .VBUS_VALID(vbus_valid),
        .SESSION_ACTIVE(session_active), .SESSION_REQ_SEEN(ev[0]), .PEER_ATTACHED(peer_attached),
        .FRAME_START_SEEN(ev[1]), .BUS_RESET_SEEN(ev[2]), .BABBLE_SEEN(ev[3]),
        .RESUME_SEEN(ev[4]), .SUSPEND_SEEN(ev[5]), .FRAME_TICK(frame_tick),
        .EP_RX_DONE(rx_done), .EP_NAK_SEEN(nak_seen), .EP_DATA_SEEN(data_seen));

    uerc_link_model uerc_link_model_inst (.clk(REF_CLK), .host_mode(host_mode),
        .vbus_valid(vbus_valid), .session_active(session_active),
        .peer_attached(peer_attached), .ev(ev), .frame_tick(frame_tick), .rx_done(rx_done),
        .nak_seen(nak_seen), .data_seen(data_seen));

    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    always @(posedge REF_CLK) begin
        for (int i = 0; i < 7; i++) begin
            if (EP_POLL_DUE[i] === 1'b1) poll_cnt[i]++;
            if (EP_NAK_TIMEOUT[i] === 1'b1) nak_cnt[i]++;
        end
    end

    // Expected pulses in n frames; bulk time-outs when nak is set, polls otherwise.
    function automatic int exp_count(logic [15:0] c, int n, logic nak);
        int m;
        int per;
        m = int'(c[15:8]);
        per = 0;
        if (nak) begin
            if (c[5:4] == UERC_PRO_BULK && m >= 2 && m <= 16) per = 1 << (m - 1);
        end else if (c[5:4] == UERC_PRO_INTR && c[7:6] != UERC_SPD_HIGH) begin
            per = m;
        end else if (c[5:4] inside {UERC_PRO_INTR, UERC_PRO_ISO} && m >= 1 && m <= 16) begin
            per = 1 << (m - 1);
        end
        return (per == 0) ? 0 : n / per;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        @(posedge REF_CLK);
        HSEL <= 1'b1;
        HADDR <= {24'h00_0000, ofs};
        HTRANS <= UERC_HTRANS_NONSEQ;
        HWRITE <= wr;
        HSIZE <= UERC_HSIZE_WORD;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask

    task automatic rdchk(input logic [7:0] ofs, input logic [31:0] exp);
        bus(1'b0, ofs, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge REF_CLK);
        n_mismatch++;
        summarize();
    end

    initial begin
        {RST_N, HSEL, HWRITE, HTRANS, HSIZE, HADDR, HWDATA} = '0;
        repeat (5) @(posedge REF_CLK);
        RST_N <= 1'b1;
        rdchk(UERC_OFS_EVT, 32'h0600_00FE);
        rdchk(UERC_OFS_IRQ_MASK, 32'h0000_00FF);
        bus(1'b1, UERC_OFS_EVT, 32'hFFFF_FFFF);
        rdchk(UERC_OFS_EVT, 32'hFF00_00FE);
        w = $random(seed);
        bus(1'b1, UERC_OFS_EVT, w);
        rdchk(UERC_OFS_EVT, {w[31:24], 16'h0000, w[7:1], 1'b0});
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        rdchk(8'h20, 32'h0000_0000);
        chk({31'h0, HRESP}, 32'h0000_0000);
        bus(1'b1, UERC_OFS_EVT, 32'hFF00_00FE);
        $display("test registers finished, mismatches %0d", n_mismatch);
        for (int i = 0; i < 16; i++) begin
            uerc_link_model_inst.act(ev_tab[i][12], ev_tab[i][11:8]);
            repeat (4) @(posedge REF_CLK);
            chk({31'h0, IRQ}, {31'h0, ev_tab[i][7:0] != 8'h00});
            rdchk(UERC_OFS_IRQ_STAT, {24'h0, ev_tab[i][7:0]});
            rdchk(UERC_OFS_IRQ_STAT, 32'h0000_0000);
            chk({31'h0, IRQ}, 32'h0000_0000);
        end
        rdchk(UERC_OFS_EVT, 32'hFFFF_00FE);
        bus(1'b1, UERC_OFS_EVT, 32'h0000_00FE);
        uerc_link_model_inst.act(1'b1, 4'h4);
        uerc_link_model_inst.act(1'b1, 4'h7);
        repeat (4) @(posedge REF_CLK);
        chk({31'h0, IRQ}, 32'h0000_0000);
        rdchk(UERC_OFS_IRQ_STAT, 32'h0000_0000);
        bus(1'b1, UERC_OFS_EVT, 32'hFF00_00FE);
        bus(1'b1, UERC_OFS_IRQ_MASK, 32'h0000_0000);
        uerc_link_model_inst.act(1'b1, 4'h8);
        repeat (4) @(posedge REF_CLK);
        chk({31'h0, IRQ}, 32'h0000_0000);
        bus(1'b1, UERC_OFS_IRQ_MASK, 32'h0000_00FF);
        repeat (3) @(posedge REF_CLK);
        chk({31'h0, IRQ}, 32'h0000_0001);
        rdchk(UERC_OFS_IRQ_STAT, 32'h0000_0001);
        $display("test events finished, mismatches %0d", n_mismatch);
        uerc_link_model_inst.rx(7'h05);
        repeat (4) @(posedge REF_CLK);
        chk({25'h0, EP_RX_IRQ}, 32'h0000_0005);
        rdchk(UERC_OFS_EP_STAT, 32'h0000_0005);
        rdchk(UERC_OFS_EP_STAT, 32'h0000_0000);
        chk({25'h0, EP_RX_IRQ}, 32'h0000_0000);
        bus(1'b1, UERC_OFS_EVT, 32'hFF00_0002);
        uerc_link_model_inst.rx(7'h05);
        repeat (4) @(posedge REF_CLK);
        rdchk(UERC_OFS_EP_STAT, 32'h0000_0001);
        $display("test endpoint receive finished, mismatches %0d", n_mismatch);
        for (int e = 1; e <= 7; e++) begin
            w = $random(seed);
            cfg[e] = {w[15:8], e[1:0], e[2:1], w[3:0]};
            bus(1'b1, UERC_OFS_EP_SEL, e);
            bus(1'b1, UERC_OFS_CFG, {w[31:16], cfg[e]});
        end
        for (int e = 1; e <= 7; e++) begin
            bus(1'b1, UERC_OFS_EP_SEL, e);
            rdchk(UERC_OFS_CFG, {16'h0000, cfg[e]});
            bus(1'b1, UERC_OFS_CFG, {16'h0000, t_cfg[e]});
        end
        uerc_link_model_inst.frames(12, 7'h7F, 7'h00);
        uerc_link_model_inst.frames(3, 7'h7F, 7'h00);
        uerc_link_model_inst.frames(1, 7'h00, 7'h7F);
        uerc_link_model_inst.frames(3, 7'h7F, 7'h00);
        repeat (6) @(posedge REF_CLK);
        for (int e = 1; e <= 7; e++) begin
            chk(poll_cnt[e-1], exp_count(t_cfg[e], 19, 1'b0));
            chk(nak_cnt[e-1], exp_count(t_cfg[e], 12, 1'b1));
        end
        $display("test timers finished, mismatches %0d", n_mismatch);
        summarize();
    end
endmodule
`default_nettype wire
